// ### core/sss_cfg.svh
// Constants of the serial port and error supervisor
`ifndef SSS_CFG_SVH
`define SSS_CFG_SVH

// ==========================================================================
// Frame and address layout
`define SSS_FRAME_BITS      16
`define SSS_HI_MSB          15
`define SSS_HI_LSB          12
`define SSS_LO_MSB          11
`define SSS_LO_LSB          8
`define SSS_ADDR_NOP        4'h0
`define SSS_ADDR_CR_FIRST   4'h1
`define SSS_ADDR_CR_LAST    4'h7
`define SSS_ADDR_SR0        4'h8
`define SSS_NOP_DATA        8'h00

// ==========================================================================
// Control register indices, fields and reset values
`define SSS_CR1             3'h1
`define SSS_CR3             3'h3
`define SSS_CR7             3'h7
`define SSS_CR1_DIRECTION_POLARITY        7
`define SSS_CR1_MOTEN       4
`define SSS_CR3_SLEEP       3
`define SSS_CR7_BEMF_EN     5
`define SSS_CR7_UV_MSB      4
`define SSS_CR1_RST         8'h00
`define SSS_CR2_RST         8'h00
`define SSS_CR3_RST         8'h20
`define SSS_CR4_RST         8'h10
`define SSS_CR5_RST         8'h00
`define SSS_CR6_RST         8'h00
`define SSS_CR7_RST         8'h00

// ==========================================================================
// Status register 0 fields
`define SSS_SR0_RESET       7
`define SSS_SR0_TW          6
`define SSS_SR0_TSD         5
`define SSS_SR0_SPI         4

// ==========================================================================
// Timing
`define SSS_CLK_MHZ         25
`define SSS_T_HR_ERR_US     100
`define SSS_HR_ERR_CYC      (`SSS_T_HR_ERR_US * `SSS_CLK_MHZ)
`define SSS_T_WAKEUP_US     50
`define SSS_WAKEUP_CYC      (`SSS_T_WAKEUP_US * `SSS_CLK_MHZ)
`define SSS_T_TRIG_US       1000
`define SSS_TRIG_CYC        (`SSS_T_TRIG_US * `SSS_CLK_MHZ)
`define SSS_HR_EDGES        4'hA

`endif

// ### core/sss_pkg.sv
// Types of the serial port and error supervisor
package sss_pkg;

    // ======================================================================
    // Operating states
    typedef enum logic [3:0] {
        ST_RESET = 4'b0001,
        ST_SLEEP = 4'b0010,
        ST_WAKE  = 4'b0100,
        ST_RUN   = 4'b1000
    } sss_state_t;

    typedef logic [7:1][7:0] sss_ctrl_t;

    // ======================================================================
    // System domain state
    typedef struct packed {
        sss_state_t  st;
        logic [15:0] tmr;
        sss_ctrl_t   cr;
        logic        spi_err;
        logic        thermal_shutdown_flag;
        logic        tw;
        logic        hr_flag;
        logic        tsd_read;
        logic        tw_read;
        logic [3:0]  rise_cnt;
        logic [15:0] win;
        logic        dir_prev;
        logic        cs_prev;
        logic        frm_last;
        logic        skip;
        logic [15:0] tx;
        logic        err;
        logic        bridge;
        logic        sleep;
    } sss_sys_t;

endpackage

// ### core/sss_top.sv
// Serial slave port with thermal, framing, sleep and reset supervision
//
// Behaviour
// (R01) Warning sets flag, error low, bridges on
// (R02) Shutdown sets flag, error, bridges off, no reset
// (R03) Shutdown clears after read and cool down
// (R04) Bridge enable write only with thermal flags clear
// (R05) Host polls status registers periodically
// (R06) Edge count not multiple of 16 flags error
// (R07) Bad frame writes nothing, loads no response
// (R08) Good status 0 read clears framing error
// (R09) Error output ORs all faults, off in sleep
// (R10) Sleep after reset or on sleep request
// (R11) Sleep refuses serial, disables bridges, keeps registers
// (R12) Chip select fall wakes, clears sleep request
// (R13) Sleep blocks hard reset, freezes thermal shutdown
// (R14) Reset sets flag, error low, then sleep
// (R15) Ten direction patterns in hold reset everything
// (R16) Host enters hold before hard reset pattern
// (R17) Slave only, sixteen bit transfers
// (R18) Active low select, output released when idle
// (R19) Output on falling, sample on rising edge
// (R20) Upper nibble control address writes data byte
// (R21) Lower control or any status address reads
// (R22) Two byte answer next frame, nop gives zero
// (R23) Bridge enable bit drives the bridges
// (R24) Answer comes from last addresses received
// (R25) Shift register on serial clock, decode at deselect
`timescale 1ns/10ps
`default_nettype none
`include "sss_cfg.svh"

module sss_top #(
    parameter logic [15:0] TRIG_CYC = 16'(`SSS_TRIG_CYC)
) (
    input  wire logic       clk_sys_i,
    input  wire logic       arst_n_i,
    input  wire logic       sclk_i,
    input  wire logic       cs_n_i,
    input  wire logic       serial_in_i,
    output logic            serial_out_o,
    output logic            serial_out_oe_o,
    input  wire logic       tw_i,
    input  wire logic       tsd_i,
    input  wire logic       short_i,
    input  wire logic       open_coil_x_i,
    input  wire logic       open_coil_y_i,
    input  wire logic       stall_i,
    input  wire logic       backemf_result_i,
    input  wire logic [4:0] undervolt_i,
    input  wire logic       dir_i,
    input  wire logic       hold_i,
    output logic            error_out_n_o,
    output logic            error_out_n_oe_o,
    output logic            bridge_en_o,
    output logic            sleep_o
);

    // ======================================================================
    // Reset release and input synchronisers
    localparam int NSYNC = 17;

    logic             rst_meta;
    logic             rst_n;
    logic [NSYNC-1:0] in_meta;
    logic [NSYNC-1:0] in_sync;
    logic             frm_tgl;
    logic             odd;
    logic [15:0]      shift;

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            in_meta <= '1;
            in_sync <= '1;
        end else begin
            in_meta <= {frm_tgl, odd, cs_n_i, tw_i, tsd_i, short_i, open_coil_x_i,
                        open_coil_y_i, stall_i, backemf_result_i, undervolt_i,
                        dir_i, hold_i};
            in_sync <= in_meta;
        end
    end

    logic       frm_s;
    logic       odd_s;
    logic       cs_s;
    logic       tw_s;
    logic       tsd_s;
    logic       short_s;
    logic       open_coil_x_flag_s;
    logic       open_coil_y_flag_s;
    logic       stall_s;
    logic       bemf_s;
    logic [4:0] uv_s;
    logic       dir_s;
    logic       hold_s;

    assign {frm_s, odd_s, cs_s, tw_s, tsd_s, short_s, open_coil_x_flag_s, open_coil_y_flag_s, stall_s,
            bemf_s, uv_s, dir_s, hold_s} = in_sync;

    // ======================================================================
    // Link side, clocked by the serial clock
    logic [3:0] bit_cnt;
    logic       started;
    logic [3:0] out_idx;

    // (R17) Slave only, sixteen bit count
    // (R25) Edge count restarts per frame
    always_ff @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            bit_cnt <= 4'h0;
            started <= 1'b0;
        end else begin
            bit_cnt <= bit_cnt + 4'h1;
            started <= 1'b1;
        end
    end

    // (R19) Sample on rising edge
    // Shift word and edge parity are read only after deselect, when idle
    always_ff @(posedge sclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            shift   <= 16'h0000;
            odd     <= 1'b0;
            frm_tgl <= 1'b0;
        end else begin
            shift   <= {shift[14:0], serial_in_i};
            // (R06) Track count modulo sixteen
            odd     <= (bit_cnt != 4'hF);
            frm_tgl <= frm_tgl ^ ~started;
        end
    end

    // (R19) Output changes on falling edge
    always_ff @(negedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            out_idx <= 4'h0;
        end else begin
            out_idx <= out_idx + 4'h1;
        end
    end

    sss_pkg::sss_sys_t r;
    sss_pkg::sss_sys_t n;

    // Response word is held still from deselect to the next frame
    // (R24) Repeat last response per word
    assign serial_out_o = r.tx[4'hF - out_idx];
    // (R18) Driven only while selected and not in sleep
    assign serial_out_oe_o = ~cs_n_i & ~r.sleep;

    // ======================================================================
    // Helpers
    function automatic logic is_ctrl(input logic [3:0] a);
        is_ctrl = (a >= `SSS_ADDR_CR_FIRST) && (a <= `SSS_ADDR_CR_LAST);
    endfunction

    // (R22) Register read, nop and unmapped give zero
    function automatic logic [7:0] rd_reg(input logic [3:0] a,
                                          input sss_pkg::sss_ctrl_t cr,
                                          input logic [7:0] sr0);
        if (is_ctrl(a)) begin
            rd_reg = cr[a[2:0]];
        end else if (a == `SSS_ADDR_SR0) begin
            rd_reg = sr0;
        end else begin
            rd_reg = `SSS_NOP_DATA;
        end
    endfunction

    function automatic sss_pkg::sss_sys_t reset_val();
        sss_pkg::sss_sys_t v;
        v          = '0;
        v.st       = sss_pkg::ST_RESET;
        v.cr[1]    = `SSS_CR1_RST;
        v.cr[2]    = `SSS_CR2_RST;
        v.cr[3]    = `SSS_CR3_RST;
        v.cr[4]    = `SSS_CR4_RST;
        v.cr[5]    = `SSS_CR5_RST;
        v.cr[6]    = `SSS_CR6_RST;
        v.cr[7]    = `SSS_CR7_RST;
        v.hr_flag  = 1'b1;
        v.cs_prev  = 1'b1;
        v.err      = 1'b1;
        return v;
    endfunction

    // ======================================================================
    // Supervisor
    always_comb begin
        logic       awake;
        logic       cs_fall;
        logic       cs_rise;
        logic       eff_dir;
        logic [3:0] a_hi;
        logic [3:0] a_lo;
        logic [7:0] dat;
        logic [7:0] sr0;
        logic       fault;
        awake   = (r.st == sss_pkg::ST_WAKE) || (r.st == sss_pkg::ST_RUN);
        cs_fall = r.cs_prev & ~cs_s;
        cs_rise = ~r.cs_prev & cs_s;
        eff_dir = dir_s ^ r.cr[`SSS_CR1][`SSS_CR1_DIRECTION_POLARITY];
        a_hi    = shift[`SSS_HI_MSB:`SSS_HI_LSB];
        a_lo    = shift[`SSS_LO_MSB:`SSS_LO_LSB];
        dat     = shift[7:0];
        sr0     = 8'h00;
        sr0[`SSS_SR0_RESET] = r.hr_flag;
        sr0[`SSS_SR0_TW]    = r.tw;
        sr0[`SSS_SR0_TSD]   = r.thermal_shutdown_flag;
        sr0[`SSS_SR0_SPI]   = r.spi_err;

        n         = r;
        n.cs_prev = cs_s;
        n.dir_prev = eff_dir;

        unique case (r.st)
            sss_pkg::ST_RESET: begin
                // (R14) Hold reset state, then sleep
                n.hr_flag = 1'b1;
                if (r.tmr == 16'(`SSS_HR_ERR_CYC - 1)) begin
                    n.st  = sss_pkg::ST_SLEEP;
                    n.tmr = 16'h0000;
                end else begin
                    n.tmr = r.tmr + 16'h0001;
                end
            end
            sss_pkg::ST_SLEEP: begin
                // (R12) Select fall wakes, clears request
                if (cs_fall) begin
                    n.st = sss_pkg::ST_WAKE;
                    n.tmr = 16'h0000;
                    n.skip = 1'b1;
                    n.cr[`SSS_CR3][`SSS_CR3_SLEEP] = 1'b0;
                end
            end
            sss_pkg::ST_WAKE: begin
                if (r.tmr == 16'(`SSS_WAKEUP_CYC - 1)) begin
                    n.st = sss_pkg::ST_RUN;
                end else begin
                    n.tmr = r.tmr + 16'h0001;
                end
            end
            sss_pkg::ST_RUN: begin
            end
        endcase

        if (awake) begin
            // (R03) Clear after readout and cool down
            if (r.tsd_read && !tw_s) begin
                n.thermal_shutdown_flag      = 1'b0;
                n.tsd_read = 1'b0;
            end
            if (r.tw_read && !tw_s) begin
                n.tw      = 1'b0;
                n.tw_read = 1'b0;
            end
            // (R01) Warning flag only
            if (tw_s) begin
                n.tw = 1'b1;
            end
            // (R13) Shutdown handled only while awake
            // (R02) Shutdown drops bridge enable
            if (tsd_s) begin
                n.thermal_shutdown_flag = 1'b1;
                n.cr[`SSS_CR1][`SSS_CR1_MOTEN] = 1'b0;
            end
        end

        // (R11) Frames that began in sleep are refused
        // Every deselect records the toggle, refused frames too
        if (cs_rise) begin
            n.skip     = 1'b0;
            n.frm_last = frm_s;
        end
        // (R25) Decode at deselect
        if (awake && cs_rise && !r.skip && (frm_s != r.frm_last)) begin
            n.frm_last = frm_s;
            if (odd_s) begin
                // (R07) Bad frame discarded entirely
                n.spi_err = 1'b1;
            end else begin
                // (R20) Write by upper nibble only
                if (is_ctrl(a_hi)) begin
                    n.cr[a_hi[2:0]] = dat;
                    // (R04) Enable accepted only when cool
                    if (a_hi[2:0] == `SSS_CR1 && (r.thermal_shutdown_flag || r.tw || tsd_s)) begin
                        n.cr[`SSS_CR1][`SSS_CR1_MOTEN] = n.cr[`SSS_CR1][`SSS_CR1_MOTEN]
                                                         & r.cr[`SSS_CR1][`SSS_CR1_MOTEN]
                                                         & ~tsd_s;
                    end
                end
                // (R21) Read by either nibble
                // (R22) Upper byte first, lower second
                n.tx = {rd_reg(a_hi, n.cr, sr0), rd_reg(a_lo, n.cr, sr0)};
                // (R08) Good status 0 read clears error
                if (a_hi == `SSS_ADDR_SR0 || a_lo == `SSS_ADDR_SR0) begin
                    n.spi_err  = 1'b0;
                    n.hr_flag  = 1'b0;
                    n.tsd_read = r.thermal_shutdown_flag | n.tsd_read;
                    n.tw_read  = r.tw | n.tw_read;
                end
            end
        end

        // (R10) Sleep on request
        if (awake && n.cr[`SSS_CR3][`SSS_CR3_SLEEP]) begin
            n.st = sss_pkg::ST_SLEEP;
        end

        // (R15) Direction pattern counter in hold
        // (R13) Blocked in sleep and over temperature
        if (r.st == sss_pkg::ST_RUN && hold_s && !r.thermal_shutdown_flag && !tsd_s) begin
            if (r.win != 16'hFFFF) begin
                n.win = r.win + 16'h0001;
            end
            if (eff_dir && !r.dir_prev) begin
                n.win = 16'h0000;
                if (r.rise_cnt == 4'h0 || r.win < TRIG_CYC) begin
                    n.rise_cnt = r.rise_cnt + 4'h1;
                end else begin
                    n.rise_cnt = 4'h1;
                end
            end
        end else begin
            n.rise_cnt = 4'h0;
            n.win      = 16'h0000;
        end

        // (R09) Fault combination, silent in sleep
        fault = n.spi_err | short_s | open_coil_x_flag_s | open_coil_y_flag_s | n.thermal_shutdown_flag | n.tw | stall_s
              | (r.cr[`SSS_CR7][`SSS_CR7_BEMF_EN] & bemf_s)
              | (|(r.cr[`SSS_CR7][`SSS_CR7_UV_MSB:0] & uv_s))
              | (n.st == sss_pkg::ST_RESET);
        n.sleep  = (n.st == sss_pkg::ST_SLEEP);
        n.err    = fault & ~n.sleep;
        // (R23) Bridges follow enable bit
        // (R11) Bridges off in sleep
        n.bridge = n.cr[`SSS_CR1][`SSS_CR1_MOTEN] & ~n.thermal_shutdown_flag
                 & ((n.st == sss_pkg::ST_WAKE) || (n.st == sss_pkg::ST_RUN));

        // (R15) Hard reset restarts the whole state
        if (n.rise_cnt == `SSS_HR_EDGES) begin
            n = reset_val();
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            r <= reset_val();
        end else begin
            r <= n;
        end
    end

    // ======================================================================
    // Outputs
    // Open drain: pin level is always low, enable carries the fault
    assign error_out_n_o    = 1'b0;
    assign error_out_n_oe_o = r.err;
    assign bridge_en_o      = r.bridge;
    assign sleep_o          = r.sleep;

endmodule

`default_nettype wire

// ### testbench/sss_spi_mst.sv
// Serial master model for the supervisor port
`timescale 1ns/10ps
`default_nettype none
module sss_spi_mst (
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      mosi_o,
    input  wire logic miso_i
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // drive on fall, sample on rise, n edges
    task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
        r = 16'h0000;
        cs_n_o = 1'b0;
        #20;
        for (int i = 0; i < n; i++) begin
            mosi_o = w[15 - (i % 16)];
            #3 sclk_o = 1'b1;
            r = {r[14:0], miso_i};
            #3 sclk_o = 1'b0;
        end
        #10 cs_n_o = 1'b1;
        // Released line must not keep the last bit
        mosi_o = ~mosi_o;
        #400;
    endtask
endmodule
`default_nettype wire

// ### testbench/sss_top_chk.sv
// Concurrent checks on the supervisor top ports
`timescale 1ns/10ps
`default_nettype none
module sss_top_chk (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic cs_n_i,
    input wire logic tw_i,
    input wire logic tsd_i,
    input wire logic short_i,
    input wire logic serial_out_oe_o,
    input wire logic error_out_n_o,
    input wire logic error_out_n_oe_o,
    input wire logic bridge_en_o,
    input wire logic sleep_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!arst_n_i);
    // ======================================================================
    // Assertions
    a_reset_err: assert property ($rose(arst_n_i) |-> error_out_n_oe_o[*8])
        else $error("error line not held after reset");
    a_drive_low: assert property (error_out_n_o == 1'b0)
        else $error("error pin drives high");
    a_sleep_quiet: assert property (sleep_o |-> !error_out_n_oe_o && !bridge_en_o)
        else $error("outputs active in sleep");
    a_do_release: assert property (cs_n_i || sleep_o |-> !serial_out_oe_o)
        else $error("data out driven while idle");
    a_warn_err: assert property ((tw_i && !sleep_o)[*4] |=> error_out_n_oe_o || sleep_o)
        else $error("warning not flagged");
    a_tsd_off: assert property ((tsd_i && !sleep_o)[*4] |=> !bridge_en_o)
        else $error("bridges on in shutdown");
    a_fault_err: assert property ((short_i && !sleep_o)[*4] |=> error_out_n_oe_o || sleep_o)
        else $error("short not flagged");
    a_wake_cs: assert property ($fell(cs_n_i) && sleep_o |-> ##[1:6] !sleep_o)
        else $error("select fall did not wake");
    c_wake: cover property ($fell(sleep_o));
    c_bridge: cover property ($rose(bridge_en_o));
    c_err: cover property ($rose(error_out_n_oe_o) && !tw_i && !short_i);
endmodule
bind sss_top sss_top_chk i_chk (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .cs_n_i(cs_n_i), .tw_i(tw_i), .tsd_i(tsd_i), .short_i(short_i),
    .serial_out_oe_o(serial_out_oe_o), .error_out_n_o(error_out_n_o),
    .error_out_n_oe_o(error_out_n_oe_o), .bridge_en_o(bridge_en_o), .sleep_o(sleep_o));
`default_nettype wire

// ### testbench/tb_stepper_spi_error_supervisor.sv
// Self-checking bench of the serial port and error supervisor
`timescale 1ns/10ps
`default_nettype none
module tb_stepper_spi_error_supervisor;
    logic        clk_sys_i = 1'b0;
    logic        arst_n_i  = 1'b0;
    logic        tw        = 1'b0;
    logic        thermal_shutdown_flag       = 1'b0;
    logic        dir       = 1'b0;
    logic        hold      = 1'b0;
    logic [3:0]  flt       = 4'h0;
    logic [5:0]  evt       = 6'h00;
    logic [15:0] rx;
    logic [7:0]  rst [1:7] = '{8'h00, 8'h00, 8'h20, 8'h10, 8'h00, 8'h00, 8'h00};
    wire logic   sclk, cs_n, mosi, so, so_oe, err_n, err_oe, bridge, sleep_request;
    wire logic   so_w = so_oe ? so : 1'bz;
    int          fail_count = 0;
    int          checks     = 0;
    int          cyc        = 0;
    // ======================================================================
    // Clock, hang guard, design
    always #20 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            wrap_up();
        end
    end
    sss_top #(.TRIG_CYC(16'd200)) i_dut (
        .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .sclk_i(sclk), .cs_n_i(cs_n),
        .serial_in_i(mosi), .serial_out_o(so), .serial_out_oe_o(so_oe), .tw_i(tw),
        .tsd_i(thermal_shutdown_flag), .short_i(flt[0]), .open_coil_x_i(flt[1]), .open_coil_y_i(flt[2]),
        .stall_i(flt[3]), .backemf_result_i(evt[5]), .undervolt_i(evt[4:0]),
        .dir_i(dir), .hold_i(hold), .error_out_n_o(err_n), .error_out_n_oe_o(err_oe),
        .bridge_en_o(bridge), .sleep_o(sleep_request));
    sss_spi_mst i_mst (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(so_w));
    // ======================================================================
    // Helpers
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic bchk(input string nm, input logic e, input logic g);
        chk(nm, {15'h0000, e}, {15'h0000, g});
    endtask
    task automatic clks(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    task automatic fr(input logic [15:0] w, input int n = 16);
        i_mst.xfer(w, n, rx);
        @(negedge clk_sys_i);
    endtask
    task automatic wrap_up();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ======================================================================
    // Scenarios
    task automatic t_reset();
        int n = 0;
        clks(2);
        bchk("err rst", 1'b1, err_oe);
        while (sleep_request !== 1'b1 && n < 3000) begin
            clks(1);
            n++;
        end
        bchk("rst len", 1'b1, n > 2490 && n < 2510);
        bchk("err slp", 1'b0, err_oe);
        $display("reset done");
    endtask
    task automatic t_wake();
        fr(16'h0000);
        clks(2);
        bchk("wake", 1'b0, sleep_request);
        chk("do idle", 16'hzzzz, {16{so_w}});
        // Host waits out the wake-up time
        clks(1300);
        fr(16'h8000);
        fr(16'h0000);
        chk("sr0", 16'h8000, rx);
        for (int k = 1; k < 8; k++) begin
            fr({4'h0, k[3:0], 8'h00});
            fr(16'h0000);
            chk("cr rst", {8'h00, rst[k]}, rx);
        end
        $display("wake done");
    endtask
    task automatic t_write();
        fr(16'h1010);
        bchk("br on", 1'b1, bridge);
        fr(16'h0100);
        chk("wr echo", 16'h1000, rx);
        bchk("rd only", 1'b1, bridge);
        fr(16'h0000);
        chk("rd cr1", 16'h0010, rx);
        $display("write done");
    endtask
    task automatic t_frame();
        fr(16'h0100);
        fr(16'h1000, 15);
        bchk("spi err", 1'b1, err_oe);
        bchk("no wr", 1'b1, bridge);
        fr(16'h0000);
        chk("tx kept", 16'h0010, rx);
        bchk("err kept", 1'b1, err_oe);
        fr(16'h8000, 32);
        bchk("err clr", 1'b0, err_oe);
        fr(16'h0000);
        chk("spi bit", 16'h1000, rx);
        $display("frame done");
    endtask
    task automatic t_therm();
        tw = 1'b1;
        clks(6);
        bchk("tw err", 1'b1, err_oe);
        bchk("tw br", 1'b1, bridge);
        thermal_shutdown_flag = 1'b1;
        clks(6);
        bchk("tsd br", 1'b0, bridge);
        thermal_shutdown_flag = 1'b0;
        fr(16'h8000);
        fr(16'h1010);
        bchk("tsd hold", 1'b1, err_oe);
        bchk("no en", 1'b0, bridge);
        tw = 1'b0;
        clks(6);
        bchk("cool", 1'b0, err_oe);
        fr(16'h1010);
        bchk("re en", 1'b1, bridge);
        $display("thermal done");
    endtask
    task automatic t_faults();
        evt = 6'h3F;
        clks(6);
        bchk("evt off", 1'b0, err_oe);
        evt = 6'h00;
        fr(16'h703F);
        for (int i = 0; i < 10; i++) begin
            {evt, flt} = 10'h001 << i;
            clks(6);
            bchk("fault", 1'b1, err_oe);
            {evt, flt} = 10'h000;
            clks(6);
            bchk("fault clr", 1'b0, err_oe);
        end
        $display("faults done");
    endtask
    task automatic t_sleep();
        fr(16'h3028);
        bchk("slp", 1'b1, sleep_request);
        bchk("slp br", 1'b0, bridge);
        tw = 1'b1;
        clks(6);
        bchk("slp err", 1'b0, err_oe);
        tw = 1'b0;
        fr(16'h0000);
        clks(1300);
        bchk("br back", 1'b1, bridge);
        fr(16'h0300);
        fr(16'h0000);
        chk("slp clr", 16'h0020, rx);
        $display("sleep done");
    endtask
    task automatic t_hard();
        hold = 1'b1;
        clks(10);
        repeat (10) begin
            dir = 1'b1;
            clks(4);
            dir = 1'b0;
            clks(4);
        end
        clks(6);
        bchk("hr err", 1'b1, err_oe);
        bchk("hr awake", 1'b0, sleep_request);
        hold = 1'b0;
        clks(2600);
        bchk("hr slp", 1'b1, sleep_request);
        $display("hard reset done");
    endtask
    initial begin
        clks(6);
        arst_n_i = 1'b1;
        t_reset();
        t_wake();
        t_write();
        t_frame();
        t_therm();
        t_faults();
        t_sleep();
        t_hard();
        wrap_up();
    end
endmodule
`default_nettype wire
